// ### ptaa_core.sv
// Product term array, allocator and shared control terms of one logic block
`timescale 1ns/1ps
`default_nettype none
module ptaa_core #(
	parameter int N_IN = 36,
	parameter int N_MC = 16
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Global routing pool side
	input wire logic [ptaa_pkg::NUM_INPUTS-1:0] GLOBAL_ROUTING_POOL_IN,
	output logic [ptaa_pkg::NUM_SLICES-1:0] GLOBAL_ROUTING_POOL_OUT,
	// Output routing pool side
	output logic [ptaa_pkg::NUM_SLICES-1:0] OUTPUT_ROUTING_POOL_OUT,
	// Shared control terms toward the macrocells
	output logic SHARED_CLK,
	output logic SHARED_INIT,
	output logic SHARED_OE,
	// Configuration load
	input wire logic CFG_WE,
	input wire logic [ptaa_pkg::CFG_ADDR_W-1:0] CFG_ADDR,
	input wire logic [ptaa_pkg::NUM_LINES-1:0] CFG_DATA,
	input wire logic CFG_LOCK
);
	import ptaa_pkg::*;

	generate
		if (N_IN != NUM_INPUTS || N_MC != NUM_SLICES) begin : g_bad
			$error("ptaa_core serves only 36 inputs and 16 macrocells");
		end
		// The package constants must describe one consistent block
		if (NUM_LOGIC_TERMS != NUM_SLICES * CLUSTER_SIZE) begin : g_bad_split
			$error("logic terms must give one cluster per slice");
		end
		if (TERM_CLK != NUM_LOGIC_TERMS) begin : g_bad_ctrl
			$error("control terms must follow the logic terms");
		end
		if (TERM_OE != NUM_TERMS - 1) begin : g_bad_oe
			$error("enable term must be the last term");
		end
		if (NUM_NEIGHBOURS * CLUSTER_SIZE != FIXED_PATH_TERMS) begin : g_bad_fixed
			$error("fixed path must be whole clusters");
		end
		if (int'(CFG_SLICE_BASE) != NUM_TERMS) begin : g_bad_map
			$error("slice words must follow the term masks");
		end
		if (int'(CFG_CTRL_ADDR) != NUM_TERMS + NUM_SLICES) begin : g_bad_ctrl_map
			$error("control word must follow the slice words");
		end
		if (SLICE_WIDE_BIT < SLICE_DEST_LSB + DEST_W) begin : g_bad_fields
			$error("slice word fields overlap");
		end
	endgenerate

	// Product term: AND of connected lines; an empty term reads low
	function automatic logic pterm(input ptaa_lines_t lines,
			input ptaa_lines_t mask);
		pterm = (|mask) & (&(lines | ~mask));
	endfunction : pterm

	// Cluster k lands on slice k + dest - 1
	function automatic logic lands_on(input int k, input ptaa_dest_t d,
			input int n);
		lands_on = (k + int'(d) - 1) == n;
	endfunction : lands_on

	// Configuration store, loaded while unlocked
	ptaa_lines_t mask_reg [NUM_TERMS];
	ptaa_cluster_t term_en_reg [NUM_SLICES];
	ptaa_dest_t dest_reg [NUM_SLICES];
	logic [NUM_SLICES-1:0] wide_en_reg;
	logic clk_inv_reg;
	logic init_inv_reg;
	ptaa_lines_t lines;
	logic [NUM_TERMS-1:0] terms;
	wire logic [NUM_SLICES-1:0] cluster_sum;
	wire logic [NUM_SLICES-1:0] slice_sum;
	logic [NUM_NEIGHBOURS-1:0] nbr [NUM_SLICES];
	logic cfg_wr;
	logic mask_wr;
	logic slice_wr;
	logic ctrl_wr;
	int slice_idx;
	logic [NUM_SLICES-1:0] out_next;
	logic clk_next;
	logic init_next;
	logic oe_next;

	assign cfg_wr = CFG_WE & ~CFG_LOCK;
	// Slice word index, negative below the slice window
	assign slice_idx = int'(CFG_ADDR) - int'(CFG_SLICE_BASE);
	// Unmapped addresses match none of these and are dropped
	assign mask_wr = cfg_wr && int'(CFG_ADDR) < NUM_TERMS;
	assign slice_wr = cfg_wr && slice_idx >= 0 && slice_idx < NUM_SLICES;
	assign ctrl_wr = cfg_wr && CFG_ADDR == CFG_CTRL_ADDR;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int t = 0; t < NUM_TERMS; t++) begin
				mask_reg[t] <= MASK_RESET;
			end
		end else if (mask_wr) begin
			mask_reg[CFG_ADDR] <= CFG_DATA;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int s = 0; s < NUM_SLICES; s++) begin
				term_en_reg[s] <= TERM_EN_RESET;
				dest_reg[s] <= DEST_OWN;
			end
			wide_en_reg <= '0;
		end else if (slice_wr) begin
			term_en_reg[slice_idx] <=
				CFG_DATA[SLICE_EN_LSB +: CLUSTER_SIZE];
			dest_reg[slice_idx] <= CFG_DATA[SLICE_DEST_LSB +: DEST_W];
			wide_en_reg[slice_idx] <= CFG_DATA[SLICE_WIDE_BIT];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			clk_inv_reg <= 1'b0;
			init_inv_reg <= 1'b0;
		end else if (ctrl_wr) begin
			clk_inv_reg <= CFG_DATA[CTRL_CLK_INV_BIT];
			init_inv_reg <= CFG_DATA[CTRL_INIT_INV_BIT];
		end
	end

	// inputs come only from the pool
	// Feedback from this block arrives here too, through the pool
	assign lines = {~GLOBAL_ROUTING_POOL_IN, GLOBAL_ROUTING_POOL_IN};

	// Empty masks keep unused terms low instead of high
	// wired-AND array
	always_comb begin
		for (int t = 0; t < NUM_TERMS; t++) begin
			terms[t] = pterm(lines, mask_reg[t]);
		end
	end

	// four clusters give twenty terms
	// Off-range targets are dropped, so edge clusters can be lost
	always_comb begin
		for (int n = 0; n < NUM_SLICES; n++) begin
			for (int d = 0; d < NUM_NEIGHBOURS; d++) begin
				nbr[n][d] = 1'b0;
				if (n + 1 - d >= 0 && n + 1 - d < NUM_SLICES) begin
					nbr[n][d] = cluster_sum[n + 1 - d] &
						lands_on(n + 1 - d, dest_reg[n + 1 - d], n);
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SLICES; g++) begin : g_slice
			ptaa_slice_if sif ();
			assign sif.terms = terms[g * CLUSTER_SIZE +: CLUSTER_SIZE];
			assign sif.term_en = term_en_reg[g];
			assign sif.wide_en = wide_en_reg[g];
			assign sif.nbr_sum = nbr[g];
			if (g == 0) begin : g_head
				assign sif.wide_in = 1'b0;
			end else begin : g_link
				assign sif.wide_in = slice_sum[g - 1];
			end
			assign cluster_sum[g] = sif.cluster_sum;
			assign slice_sum[g] = sif.sum;
			ptaa_slice u_slice (
				.sl(sif.slice)
			);
		end
	endgenerate

	// Outputs stay low until the configuration is locked in
	assign out_next = CFG_LOCK ? slice_sum : '0;
	assign clk_next = CFG_LOCK & (terms[TERM_CLK] ^ clk_inv_reg);
	assign init_next = CFG_LOCK & (terms[TERM_INIT] ^ init_inv_reg);
	assign oe_next = CFG_LOCK & terms[TERM_OE];

	// Registered so every block answers the pool one edge later
	// back to the pool
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			GLOBAL_ROUTING_POOL_OUT <= '0;
		end else begin
			GLOBAL_ROUTING_POOL_OUT <= out_next;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			OUTPUT_ROUTING_POOL_OUT <= '0;
		end else begin
			OUTPUT_ROUTING_POOL_OUT <= out_next;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SHARED_CLK <= 1'b0;
			SHARED_INIT <= 1'b0;
			SHARED_OE <= 1'b0;
		end else begin
			SHARED_CLK <= clk_next;
			SHARED_INIT <= init_next;
			SHARED_OE <= oe_next;
		end
	end
endmodule : ptaa_core
`default_nettype wire

// ### ptaa_core_assertions.sv
// Port checker for the product term array block
`timescale 1ns/1ps
`default_nettype none
module ptaa_core_assertions (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Pool sides
	input wire logic [ptaa_pkg::NUM_INPUTS-1:0] GLOBAL_ROUTING_POOL_IN,
	input wire logic [ptaa_pkg::NUM_SLICES-1:0] GLOBAL_ROUTING_POOL_OUT,
	input wire logic [ptaa_pkg::NUM_SLICES-1:0] OUTPUT_ROUTING_POOL_OUT,
	// Control terms and lock
	input wire logic SHARED_CLK,
	input wire logic SHARED_INIT,
	input wire logic SHARED_OE,
	input wire logic CFG_LOCK
);
	import ptaa_pkg::*;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// Locked with unchanged inputs: config is frozen
	sequence s_steady;
		CFG_LOCK && $past(CFG_LOCK) && $stable(GLOBAL_ROUTING_POOL_IN);
	endsequence
	a_out_pool_mirror: assert property (
		OUTPUT_ROUTING_POOL_OUT == GLOBAL_ROUTING_POOL_OUT)
		else $error("output pool copy differs");
	a_unlock_sums_zero: assert property (!CFG_LOCK |=>
		GLOBAL_ROUTING_POOL_OUT == '0)
		else $error("sums not forced low while loading");
	a_unlock_ctrl_zero: assert property (!CFG_LOCK |=>
		!(SHARED_CLK || SHARED_INIT || SHARED_OE))
		else $error("control terms not forced low while loading");
	a_sums_hold: assert property (s_steady |=>
		$stable(GLOBAL_ROUTING_POOL_OUT))
		else $error("sums moved with steady inputs");
	a_clk_hold: assert property (s_steady |=> $stable(SHARED_CLK))
		else $error("clock term moved with steady inputs");
	a_init_hold: assert property (s_steady |=> $stable(SHARED_INIT))
		else $error("init term moved with steady inputs");
	a_oe_hold: assert property (s_steady |=> $stable(SHARED_OE))
		else $error("enable term moved with steady inputs");
	a_no_local_loop: assert property (s_steady ##1 s_steady |=>
		$stable(GLOBAL_ROUTING_POOL_OUT) && $stable(SHARED_OE))
		else $error("outputs change without input change");
endmodule : ptaa_core_assertions
bind ptaa_core ptaa_core_assertions chk (.*);
`default_nettype wire

// ### ptaa_core_test.sv
// Self-checking bench for the product term array block
`timescale 1ns/1ps
`default_nettype none
module ptaa_core_test;
	import ptaa_pkg::*;
	logic ref_clk = 0;
	logic rst = 1;
	logic cfg_we = 0;
	logic cfg_lock = 0;
	logic [CFG_ADDR_W-1:0] cfg_addr = '0;
	ptaa_lines_t cfg_data = '0;
	logic [NUM_INPUTS-1:0] pool_val = '0;
	logic [NUM_INPUTS-1:0] pool_in;
	logic [NUM_SLICES-1:0] pool_out;
	logic [NUM_SLICES-1:0] io_out;
	logic s_clk, s_init, s_oe;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	initial forever #20 ref_clk = ~ref_clk;
	ptaa_pool_model pool (.REF_CLK(ref_clk), .POOL_VAL(pool_val),
		.ROUTED_LINES(pool_in));
	ptaa_core dut (.REF_CLK(ref_clk), .RST(rst),
		.GLOBAL_ROUTING_POOL_IN(pool_in),
		.GLOBAL_ROUTING_POOL_OUT(pool_out),
		.OUTPUT_ROUTING_POOL_OUT(io_out), .SHARED_CLK(s_clk),
		.SHARED_INIT(s_init), .SHARED_OE(s_oe), .CFG_WE(cfg_we),
		.CFG_ADDR(cfg_addr), .CFG_DATA(cfg_data), .CFG_LOCK(cfg_lock));
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic stop_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [71:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Strobe stays high between words; caller drops it
	task automatic cfg(input logic [6:0] a, input ptaa_lines_t d);
		cfg_we = 1;
		cfg_addr = a;
		cfg_data = d;
		tick(1);
	endtask : cfg
	task automatic t_route();
		logic [4:0] v;
		cfg(7'h00, 72'h1 | (72'h1 << 37));
		cfg(7'h05, 72'h10);
		cfg(7'h50, 72'h4);
		cfg(7'h51, 72'h1 << 38);
		cfg(7'h52, 72'h8);
		cfg(CFG_SLICE_BASE, 72'h21);
		cfg(CFG_SLICE_BASE + 7'h01, 72'h41);
		cfg(CFG_CTRL_ADDR, 72'h1);
		cfg(7'h64, '1);
		cfg_we = 0;
		cfg_lock = 1;
		for (int i = 0; i < 32; i++) begin
			v = i[4:0];
			pool_val = {31'h0, v};
			tick(2);
			check("pool_out", pool_out, {v[4], 1'b0, v[0] & ~v[1]});
			check("io_out", io_out, {v[4], 1'b0, v[0] & ~v[1]});
			check("ctrl", {s_clk, s_init, s_oe}, {~v[2], ~v[2], v[3]});
		end
		// Locked writes must not disturb the running array
		cfg(CFG_SLICE_BASE, 72'h0);
		cfg_we = 0;
		pool_val = 36'h1;
		tick(2);
		check("locked_wr", pool_out, 16'h0001);
	endtask : t_route
	task automatic t_wide();
		cfg_lock = 0;
		tick(1);
		check("unlocked", {pool_out, io_out, s_clk, s_init, s_oe}, 0);
		// Init inversion on, clock inversion off
		cfg(CFG_CTRL_ADDR, 72'h2);
		for (int n = 1; n < 16; n++) begin
			cfg(CFG_SLICE_BASE + n[6:0], 72'h80);
		end
		cfg_we = 0;
		cfg_lock = 1;
		tick(2);
		check("wide_on", pool_out, 16'hffff);
		pool_val = 36'h3;
		tick(2);
		check("wide_off", pool_out, 16'h0000);
		pool_val = 36'h4;
		tick(2);
		check("init_inv", {s_clk, s_init, s_oe}, 3'b110);
	endtask : t_wide
	task automatic t_steer();
		// Reset while locked must clear outputs and every stored word
		rst = 1;
		tick(2);
		check("reset", {pool_out, io_out, s_clk, s_init, s_oe}, 0);
		rst = 0;
		tick(1);
		check("cleared", {pool_out, s_clk, s_init, s_oe}, 0);
		cfg_lock = 0;
		cfg(7'h0a, 72'h1);
		cfg(7'h13, 72'h1 << 37);
		cfg(CFG_SLICE_BASE + 7'h02, 72'h01);
		cfg(CFG_SLICE_BASE + 7'h03, 72'h70);
		cfg_we = 0;
		cfg_lock = 1;
		pool_val = 36'h1;
		tick(2);
		check("steer_on", pool_out, 16'h0022);
		pool_val = 36'h2;
		tick(2);
		check("steer_off", pool_out, 16'h0000);
	endtask : t_steer
	initial begin
		tick(3);
		rst = 0;
		t_route();
		t_wide();
		t_steer();
		stop_test();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			stop_test();
		end
	end
endmodule : ptaa_core_test
`default_nettype wire

// ### ptaa_pkg.sv
// Constants and types for the product term array and allocator
package ptaa_pkg;
	localparam int NUM_INPUTS = 36;
	localparam int NUM_LINES = 2 * NUM_INPUTS;
	localparam int NUM_TERMS = 83;
	localparam int NUM_LOGIC_TERMS = 80;
	localparam int NUM_SLICES = 16;
	localparam int CLUSTER_SIZE = 5;
	localparam int CLUSTER_MAIN = 4;
	localparam int FIXED_PATH_TERMS = 20;
	localparam int WIDE_PATH_TERMS = 80;
	localparam int NUM_NEIGHBOURS = FIXED_PATH_TERMS / CLUSTER_SIZE;
	localparam int TERM_CLK = 80;
	localparam int TERM_INIT = 81;
	localparam int TERM_OE = 82;
	// Configuration address map
	localparam int CFG_ADDR_W = 7;
	localparam logic [CFG_ADDR_W-1:0] CFG_SLICE_BASE = 7'h53;
	localparam logic [CFG_ADDR_W-1:0] CFG_CTRL_ADDR = 7'h63;
	// Slice word fields
	localparam int SLICE_EN_LSB = 0;
	localparam int SLICE_DEST_LSB = 5;
	localparam int DEST_W = 2;
	localparam int SLICE_WIDE_BIT = 7;
	// Control word fields
	localparam int CTRL_CLK_INV_BIT = 0;
	localparam int CTRL_INIT_INV_BIT = 1;
	// Reset values: nothing connected, no inversion, cluster stays home
	localparam logic [NUM_LINES-1:0] MASK_RESET = 72'h0;
	localparam logic [CLUSTER_SIZE-1:0] TERM_EN_RESET = 5'h00;
	localparam logic [DEST_W-1:0] DEST_OWN = 2'h1;
	typedef logic [NUM_LINES-1:0] ptaa_lines_t;
	typedef logic [CLUSTER_SIZE-1:0] ptaa_cluster_t;
	typedef logic [DEST_W-1:0] ptaa_dest_t;
endpackage : ptaa_pkg

// ### ptaa_pool_model.sv
// Global routing pool model feeding the block inputs
`timescale 1ns/1ps
`default_nettype none
module ptaa_pool_model (
	// Clock
	input wire logic REF_CLK,
	// Bench value and routed lines
	input wire logic [35:0] POOL_VAL,
	output var logic [35:0] ROUTED_LINES
);
	initial ROUTED_LINES = '0;
	always @(posedge REF_CLK) begin
		ROUTED_LINES <= #1 POOL_VAL;
	end
endmodule : ptaa_pool_model
`default_nettype wire

// ### ptaa_slice.sv
// One macrocell slice of the logic allocator
`timescale 1ns/1ps
`default_nettype none
module ptaa_slice (
	ptaa_slice_if.slice sl
);
	import ptaa_pkg::*;
	logic main_sum;
	logic extra_sum;
	assign main_sum = |(sl.terms[CLUSTER_MAIN-1:0] & sl.term_en[CLUSTER_MAIN-1:0]);
	assign extra_sum = sl.terms[CLUSTER_MAIN] & sl.term_en[CLUSTER_MAIN];
	assign sl.cluster_sum = main_sum | extra_sum;
	// fixed and wide
	// Wide chain adds a ripple delay per slice, the price of the 80-term path
	assign sl.sum = (|sl.nbr_sum) | (sl.wide_en & sl.wide_in);
endmodule : ptaa_slice
`default_nettype wire

// ### ptaa_slice_if.sv
// Signals between the allocator core and one macrocell slice
`timescale 1ns/1ps
`default_nettype none
interface ptaa_slice_if;
	import ptaa_pkg::*;
	ptaa_cluster_t terms;
	ptaa_cluster_t term_en;
	logic wide_en;
	logic [NUM_NEIGHBOURS-1:0] nbr_sum;
	logic wide_in;
	logic cluster_sum;
	logic sum;
	modport alloc (
		output terms,
		output term_en,
		output wide_en,
		output nbr_sum,
		output wide_in,
		input cluster_sum,
		input sum
	);
	modport slice (
		input terms,
		input term_en,
		input wide_en,
		input nbr_sum,
		input wide_in,
		output cluster_sum,
		output sum
	);
endinterface : ptaa_slice_if
`default_nettype wire
